// ===== core/xrp_pkg.sv
// constants and types shared by both ends of the channel reconfiguration port
// assumes one 100 MHz clock shared by master and port, synchronous active-low reset
package xrp_pkg;

  // ****************************************************************
  // bus shape
  // ****************************************************************
  localparam int ADDR_W = 19;
  localparam int DATA_W = 8;
  localparam int CH_W = 3;
  localparam int MAX_CH = 8;
  localparam int WORD_W = 8;
  localparam int SPACE_WORDS = 256;
  localparam int MEM_WORDS = MAX_CH * SPACE_WORDS;
  localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
  localparam logic [DATA_W-1:0] DATA_FULL = 8'hFF;

  // ****************************************************************
  // channel space layout (word offset inside one channel)
  // ****************************************************************
  localparam logic [WORD_W-1:0] PMA_BASE = 8'h80;
  localparam logic [WORD_W-1:0] BRIDGE_BASE = 8'hF0;
  localparam logic [WORD_W-1:0] MODE_OFS = 8'h80;
  localparam int MODE_PAM4_BIT = 0;

  // ****************************************************************
  // error-correction port layout
  // ****************************************************************
  localparam logic [WORD_W-1:0] FEC_CTRL_OFS = 8'h00;
  localparam int FEC_EN_BIT = 0;
  localparam logic [WORD_W-1:0] FEC_CORR_OFS = 8'h10;
  localparam logic [WORD_W-1:0] FEC_UNCORR_OFS = 8'h11;
  localparam int FEC_PORTS = 6;

  // ****************************************************************
  // rate stepping policy
  // ****************************************************************
  localparam int CLK_MHZ = 100;
  localparam int PAM4_HI_GBPS = 30;
  localparam logic [7:0] MAX_STEP_GBPS = 8'h14;
  localparam int STEP_HOLD_MS = 200;
  localparam int STEP_HOLD_CYC = STEP_HOLD_MS * CLK_MHZ * 1000;
  localparam int HOLD_W = 25;

  typedef enum logic [1:0] {
    RG_NONE,
    RG_PMAIF,
    RG_PMA,
    RG_BRIDGE
  } xrp_region_e;

  // gray along idle -> fetch -> answer; answer -> idle flips both bits
  typedef enum logic [1:0] {
    DS_IDLE = 2'b00,
    DS_FETCH = 2'b01,
    DS_ANSWER = 2'b11
  } xrp_dev_state_e;

  // gray along idle -> read -> write and read -> idle; write -> idle flips both bits
  typedef enum logic [1:0] {
    MS_IDLE = 2'b00,
    MS_READ = 2'b01,
    MS_WRITE = 2'b11
  } xrp_mst_state_e;

endpackage : xrp_pkg

// ===== core/xrp_avmm_if.sv
// memory-mapped reconfiguration link between one master and one port
// assumes both ends sample on the rising edge of the shared clock
`timescale 1ns/1ns
interface xrp_avmm_if;
  logic [xrp_pkg::ADDR_W-1:0] address;
  logic read;
  logic write;
  logic [xrp_pkg::DATA_W-1:0] writedata;
  logic [xrp_pkg::DATA_W-1:0] readdata;
  logic waitrequest;

  modport dev (
    input address,
    input read,
    input write,
    input writedata,
    output readdata,
    output waitrequest
  );

  modport mst (
    output address,
    output read,
    output write,
    output writedata,
    input readdata,
    input waitrequest
  );
endinterface : xrp_avmm_if

// ===== core/xrp_device.sv
// reconfiguration port of the transceiver: channel space or error-correction block
// assumes a master on the link that holds its request while waitrequest is high
`timescale 1ns/1ns
module xrp_device #(
  parameter bit FEC_PORT = 1'b0,
  parameter int NUM_CH = 1
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  xrp_avmm_if.dev avmm,
  input wire logic [xrp_pkg::MAX_CH-1:0] pma_direct,
  input wire logic fec_corr_evt,
  input wire logic fec_uncorr_evt,
  output logic [xrp_pkg::MAX_CH-1:0] pam4_mode,
  output logic fec_enable
);

  // ****************************************************************
  // decode
  // ****************************************************************
  // one instance per channel, or NUM_CH > 1 for a shared port
  function automatic xrp_pkg::xrp_region_e region_of(
    input logic [xrp_pkg::ADDR_W-1:0] a
  );
    logic [xrp_pkg::CH_W-1:0] ch;
    logic [xrp_pkg::WORD_W-1:0] w;
    ch = a[xrp_pkg::WORD_W +: xrp_pkg::CH_W];
    w = a[xrp_pkg::WORD_W-1:0];
    if ((a >> (xrp_pkg::WORD_W + xrp_pkg::CH_W)) != '0 || int'(ch) >= NUM_CH)
      region_of = xrp_pkg::RG_NONE;
    else if (w >= xrp_pkg::BRIDGE_BASE)
      region_of = xrp_pkg::RG_BRIDGE;
    else if (w >= xrp_pkg::PMA_BASE)
      region_of = xrp_pkg::RG_PMA;
    else
      region_of = xrp_pkg::RG_PMAIF;
  endfunction : region_of

  // ****************************************************************
  // state
  // ****************************************************************
  xrp_pkg::xrp_dev_state_e state_ff, nxt_state;
  logic wait_ff, nxt_wait;
  logic [xrp_pkg::DATA_W-1:0] rdata_ff, nxt_rdata;
  logic [xrp_pkg::MAX_CH-1:0] pam4_ff, nxt_pam4;
  logic fec_en_ff, nxt_fec_en;
  logic [xrp_pkg::DATA_W-1:0] corr_ff, nxt_corr;
  logic [xrp_pkg::DATA_W-1:0] uncorr_ff, nxt_uncorr;
  // each instance owns its space, so ports never wait on each other
  logic [xrp_pkg::DATA_W-1:0] mem [xrp_pkg::MEM_WORDS];
  logic mem_we;
  logic [xrp_pkg::CH_W+xrp_pkg::WORD_W-1:0] mem_idx;
  xrp_pkg::xrp_region_e cur_region;
  logic [xrp_pkg::WORD_W-1:0] cur_word;
  logic [xrp_pkg::CH_W-1:0] cur_ch;
  logic [xrp_pkg::DATA_W-1:0] look_data;

  assign cur_region = region_of(avmm.address);
  assign cur_word = avmm.address[xrp_pkg::WORD_W-1:0];
  assign cur_ch = avmm.address[xrp_pkg::WORD_W +: xrp_pkg::CH_W];
  assign mem_idx = avmm.address[xrp_pkg::CH_W+xrp_pkg::WORD_W-1:0];

  // ****************************************************************
  // read path
  // ****************************************************************
  // reading never touches any stored value or counter
  always_comb
  begin
    look_data = xrp_pkg::DATA_ZERO;
    if (FEC_PORT)
    begin
      if (avmm.address[xrp_pkg::ADDR_W-1:xrp_pkg::WORD_W] != '0)
        look_data = xrp_pkg::DATA_ZERO;
      else if (cur_word == xrp_pkg::FEC_CORR_OFS)
        look_data = corr_ff;
      else if (cur_word == xrp_pkg::FEC_UNCORR_OFS)
        look_data = uncorr_ff;
      else
        look_data = mem[mem_idx];
    end
    else if (cur_region != xrp_pkg::RG_NONE)
      look_data = mem[mem_idx];
  end

  // ****************************************************************
  // transfer sequencing
  // ****************************************************************
  // waitrequest idles high so that a registered stall covers the request
  // edge itself; costs one extra cycle per access
  always_comb
  begin
    nxt_state = state_ff;
    nxt_wait = wait_ff;
    nxt_rdata = rdata_ff;
    nxt_pam4 = pam4_ff;
    nxt_fec_en = fec_en_ff;
    mem_we = 1'b0;
    case (state_ff)
      xrp_pkg::DS_IDLE:
      begin
        if (avmm.read || avmm.write)
          nxt_state = xrp_pkg::DS_FETCH;
      end
      xrp_pkg::DS_FETCH:
      begin
        nxt_state = xrp_pkg::DS_ANSWER;
        nxt_wait = 1'b0;
        if (avmm.read)
          nxt_rdata = look_data;
      end
      xrp_pkg::DS_ANSWER:
      begin
        nxt_state = xrp_pkg::DS_IDLE;
        nxt_wait = 1'b1;
        nxt_rdata = xrp_pkg::DATA_ZERO;
        if (avmm.write)
        begin
          // commit on the edge where the master sees the stall lifted
          if (FEC_PORT)
          begin
            if (avmm.address[xrp_pkg::ADDR_W-1:xrp_pkg::WORD_W] == '0 &&
                cur_word != xrp_pkg::FEC_CORR_OFS && cur_word != xrp_pkg::FEC_UNCORR_OFS)
              mem_we = 1'b1;
            if (avmm.address[xrp_pkg::ADDR_W-1:xrp_pkg::WORD_W] == '0 &&
                cur_word == xrp_pkg::FEC_CTRL_OFS)
              nxt_fec_en = avmm.writedata[xrp_pkg::FEC_EN_BIT];
          end
          else if (cur_region == xrp_pkg::RG_PMA && cur_word == xrp_pkg::MODE_OFS)
          begin
            // signalling change refused outside direct mode; whole byte write dropped
            mem_we = pma_direct[cur_ch];
            if (pma_direct[cur_ch])
              nxt_pam4[cur_ch] = avmm.writedata[xrp_pkg::MODE_PAM4_BIT];
          end
          else if (cur_region != xrp_pkg::RG_NONE)
            mem_we = 1'b1;
        end
      end
      default:
      begin
        nxt_state = xrp_pkg::DS_IDLE;
        nxt_wait = 1'b1;
        nxt_rdata = xrp_pkg::DATA_ZERO;
      end
    endcase
  end

  // ****************************************************************
  // statistics
  // ****************************************************************
  // saturating so a long run cannot wrap into a small count
  always_comb
  begin
    nxt_corr = corr_ff;
    nxt_uncorr = uncorr_ff;
    if (FEC_PORT && fec_en_ff && fec_corr_evt && corr_ff != xrp_pkg::DATA_FULL)
      nxt_corr = corr_ff + 8'h01;
    if (FEC_PORT && fec_en_ff && fec_uncorr_evt && uncorr_ff != xrp_pkg::DATA_FULL)
      nxt_uncorr = uncorr_ff + 8'h01;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      state_ff <= xrp_pkg::DS_IDLE;
      wait_ff <= 1'b1;
      rdata_ff <= xrp_pkg::DATA_ZERO;
      pam4_ff <= '0;
      fec_en_ff <= 1'b0;
      corr_ff <= xrp_pkg::DATA_ZERO;
      uncorr_ff <= xrp_pkg::DATA_ZERO;
    end
    else
    begin
      state_ff <= nxt_state;
      wait_ff <= nxt_wait;
      rdata_ff <= nxt_rdata;
      pam4_ff <= nxt_pam4;
      fec_en_ff <= nxt_fec_en;
      corr_ff <= nxt_corr;
      uncorr_ff <= nxt_uncorr;
    end
  end

  // ****************************************************************
  // programmable space
  // ****************************************************************
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < xrp_pkg::MEM_WORDS; i++)
        mem[i] <= xrp_pkg::DATA_ZERO;
    end
    else if (mem_we)
      mem[mem_idx] <= avmm.writedata;
  end

  assign avmm.waitrequest = wait_ff;
  assign avmm.readdata = rdata_ff;
  assign pam4_mode = pam4_ff;
  assign fec_enable = fec_en_ff;

endmodule : xrp_device

// ===== core/xrp_master.sv
// user-side reconfiguration master: masked writes done as read-modify-write
// assumes the port on the link keeps the stall until its answer is ready
`timescale 1ns/1ns
module xrp_master #(
  parameter int STEP_HOLD_CYC = xrp_pkg::STEP_HOLD_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  xrp_avmm_if.mst avmm,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [xrp_pkg::ADDR_W-1:0] cmd_addr,
  input wire logic [xrp_pkg::DATA_W-1:0] cmd_wdata,
  input wire logic [xrp_pkg::DATA_W-1:0] cmd_mask,
  input wire logic cmd_rate_step,
  input wire logic [7:0] cmd_rate_delta,
  input wire logic cmd_unsupported,
  input wire logic pam4_hi_active,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic rsp_error,
  output logic [xrp_pkg::DATA_W-1:0] rsp_data
);

  // ****************************************************************
  // state
  // ****************************************************************
  xrp_pkg::xrp_mst_state_e state_ff, nxt_state;
  logic [xrp_pkg::ADDR_W-1:0] addr_ff, nxt_addr;
  logic rd_ff, nxt_rd;
  logic wr_ff, nxt_wr;
  logic is_wr_ff, nxt_is_wr;
  logic step_ff, nxt_step;
  logic [xrp_pkg::DATA_W-1:0] wdata_ff, nxt_wdata;
  logic [xrp_pkg::DATA_W-1:0] mask_ff, nxt_mask;
  logic rdy_ff, nxt_rdy;
  logic rv_ff, nxt_rv;
  logic err_ff, nxt_err;
  logic [xrp_pkg::DATA_W-1:0] rsp_ff, nxt_rsp;
  logic [xrp_pkg::HOLD_W-1:0] hold_ff, nxt_hold;
  logic refuse;

  // ****************************************************************
  // policy
  // ****************************************************************
  // rate steps are refused, not split; splitting is left to the caller
  assign refuse = cmd_unsupported ||
                  (cmd_rate_step && pam4_hi_active && cmd_rate_delta > xrp_pkg::MAX_STEP_GBPS) ||
                  (cmd_rate_step && hold_ff != '0);

  // ****************************************************************
  // sequencing
  // ****************************************************************
  always_comb
  begin
    nxt_state = state_ff;
    nxt_addr = addr_ff;
    nxt_rd = rd_ff;
    nxt_wr = wr_ff;
    nxt_is_wr = is_wr_ff;
    nxt_step = step_ff;
    nxt_wdata = wdata_ff;
    nxt_mask = mask_ff;
    nxt_rdy = rdy_ff;
    nxt_rv = 1'b0;
    nxt_err = 1'b0;
    nxt_rsp = rsp_ff;
    nxt_hold = (hold_ff != '0) ? hold_ff - 1'b1 : hold_ff;
    case (state_ff)
      xrp_pkg::MS_IDLE:
      begin
        if (cmd_valid && rdy_ff)
        begin
          if (refuse)
          begin
            nxt_rv = 1'b1;
            nxt_err = 1'b1;
          end
          else
          begin
            nxt_state = xrp_pkg::MS_READ;
            nxt_addr = cmd_addr;
            nxt_rd = 1'b1;
            nxt_is_wr = cmd_write;
            nxt_step = cmd_rate_step;
            nxt_wdata = cmd_wdata;
            nxt_mask = cmd_mask;
            nxt_rdy = 1'b0;
          end
        end
      end
      xrp_pkg::MS_READ:
      begin
        if (!avmm.waitrequest)
        begin
          nxt_rd = 1'b0;
          if (is_wr_ff)
          begin
            nxt_state = xrp_pkg::MS_WRITE;
            nxt_wr = 1'b1;
            nxt_wdata = (avmm.readdata & ~mask_ff) | (wdata_ff & mask_ff);
          end
          else
          begin
            nxt_state = xrp_pkg::MS_IDLE;
            nxt_rsp = avmm.readdata;
            nxt_rv = 1'b1;
            nxt_rdy = 1'b1;
          end
        end
      end
      xrp_pkg::MS_WRITE:
      begin
        if (!avmm.waitrequest)
        begin
          nxt_state = xrp_pkg::MS_IDLE;
          nxt_wr = 1'b0;
          nxt_rsp = wdata_ff;
          nxt_rv = 1'b1;
          nxt_rdy = 1'b1;
          if (step_ff)
            nxt_hold = xrp_pkg::HOLD_W'(STEP_HOLD_CYC);
        end
      end
      default:
      begin
        nxt_state = xrp_pkg::MS_IDLE;
        nxt_rd = 1'b0;
        nxt_wr = 1'b0;
        nxt_rdy = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      state_ff <= xrp_pkg::MS_IDLE;
      addr_ff <= '0;
      rd_ff <= 1'b0;
      wr_ff <= 1'b0;
      is_wr_ff <= 1'b0;
      step_ff <= 1'b0;
      wdata_ff <= xrp_pkg::DATA_ZERO;
      mask_ff <= xrp_pkg::DATA_ZERO;
      rdy_ff <= 1'b1;
      rv_ff <= 1'b0;
      err_ff <= 1'b0;
      rsp_ff <= xrp_pkg::DATA_ZERO;
      hold_ff <= '0;
    end
    else
    begin
      state_ff <= nxt_state;
      addr_ff <= nxt_addr;
      rd_ff <= nxt_rd;
      wr_ff <= nxt_wr;
      is_wr_ff <= nxt_is_wr;
      step_ff <= nxt_step;
      wdata_ff <= nxt_wdata;
      mask_ff <= nxt_mask;
      rdy_ff <= nxt_rdy;
      rv_ff <= nxt_rv;
      err_ff <= nxt_err;
      rsp_ff <= nxt_rsp;
      hold_ff <= nxt_hold;
    end
  end

  assign avmm.address = addr_ff;
  assign avmm.read = rd_ff;
  assign avmm.write = wr_ff;
  assign avmm.writedata = wdata_ff;
  assign cmd_ready = rdy_ff;
  assign rsp_valid = rv_ff;
  assign rsp_error = err_ff;
  assign rsp_data = rsp_ff;

endmodule : xrp_master

// ===== testbench/xrp_assertions.sv
// link checker for the reconfiguration master and port
// assumes signals of one xrp_avmm_if, one clock, synchronous active-low reset
`timescale 1ns/1ns
module xrp_assertions (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [xrp_pkg::ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [xrp_pkg::DATA_W-1:0] writedata,
  input wire logic [xrp_pkg::DATA_W-1:0] readdata,
  input wire logic waitrequest
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  // ****************************************************************
  // last completed plain write
  // ****************************************************************
  logic [xrp_pkg::ADDR_W-1:0] wr_addr_ff, nxt_wr_addr;
  logic [xrp_pkg::DATA_W-1:0] wr_data_ff, nxt_wr_data;
  logic wr_seen_ff, nxt_wr_seen;
  logic plain_wr;

  // mode byte and unmapped writes may be dropped by the port, so not tracked
  assign plain_wr = write && !waitrequest && address[xrp_pkg::ADDR_W-1:11] == 8'h00
    && address[7:0] != xrp_pkg::MODE_OFS;

  always_comb
  begin
    nxt_wr_addr = wr_addr_ff;
    nxt_wr_data = wr_data_ff;
    nxt_wr_seen = wr_seen_ff;
    if (plain_wr)
    begin
      nxt_wr_addr = address;
      nxt_wr_data = writedata;
      nxt_wr_seen = 1'b1;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      wr_addr_ff <= '0;
      wr_data_ff <= xrp_pkg::DATA_ZERO;
      wr_seen_ff <= 1'b0;
    end
    else
    begin
      wr_addr_ff <= nxt_wr_addr;
      wr_data_ff <= nxt_wr_data;
      wr_seen_ff <= nxt_wr_seen;
    end
  end

  // ****************************************************************
  // properties
  // ****************************************************************
  AST_RD_STALL: assert property ($rose(read) |-> waitrequest ##1 waitrequest ##1 !waitrequest)
    else $error("read not stalled for two cycles");
  AST_WR_DONE: assert property ($rose(write) |-> waitrequest [*2] ##1 !waitrequest)
    else $error("write not accepted on time");
  AST_HOLD: assert property ((read || write) && waitrequest |=> $stable(address)
    && $stable(read) && $stable(write) && (!write || $stable(writedata)))
    else $error("request changed during wait state");
  AST_DATA_IDLE: assert property (waitrequest |-> readdata == xrp_pkg::DATA_ZERO)
    else $error("read data shown while stalled");
  AST_ONE_LOW: assert property (!waitrequest |=> waitrequest)
    else $error("waitrequest low for more than one cycle");
  AST_LOW_CAUSE: assert property (!waitrequest |-> (read || write) && $past(waitrequest))
    else $error("waitrequest low without a request");
  AST_SINGLE: assert property (!(read && write))
    else $error("read and write at once");
  AST_READBACK: assert property (read && !waitrequest && wr_seen_ff
    && address == wr_addr_ff |-> readdata == wr_data_ff)
    else $error("read back differs from last write");

  COV_READ: cover property (read && !waitrequest);
  COV_WRITE: cover property (write && !waitrequest);
  COV_RMW: cover property ($fell(read) && $rose(write));
endmodule : xrp_assertions

// ===== testbench/tb.sv
// self-checking bench: reconfiguration master joined to an eight-channel shared port
// assumes the core files are compiled first; hold count shortened to 16 cycles
`timescale 1ns/1ns
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module tb;
  localparam int HOLD = 16;
  logic clk_sys, rst_n, cmd_valid, cmd_write, cmd_rate_step, cmd_unsupported, pam4_hi_active;
  logic [18:0] cmd_addr, a;
  logic [7:0] cmd_wdata, cmd_mask, cmd_rate_delta, pma_direct, wd, mk;
  logic cmd_ready, rsp_valid, rsp_error, fec_enable;
  logic [7:0] rsp_data, pam4_mode;
  logic [31:0] seed;
  logic [7:0] ref_mem [0:2047];
  int n_mismatch, check_count;

  xrp_avmm_if xrp_avmm_if_i ();
  xrp_master #(.STEP_HOLD_CYC(HOLD)) xrp_master_i (.clk_sys(clk_sys), .rst_n(rst_n),
    .avmm(xrp_avmm_if_i), .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .cmd_mask(cmd_mask), .cmd_rate_step(cmd_rate_step),
    .cmd_rate_delta(cmd_rate_delta), .cmd_unsupported(cmd_unsupported),
    .pam4_hi_active(pam4_hi_active), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
    .rsp_error(rsp_error), .rsp_data(rsp_data));
  xrp_device #(.FEC_PORT(1'b0), .NUM_CH(8)) xrp_device_i (.clk_sys(clk_sys), .rst_n(rst_n),
    .avmm(xrp_avmm_if_i), .pma_direct(pma_direct), .fec_corr_evt(1'b0),
    .fec_uncorr_evt(1'b0), .pam4_mode(pam4_mode), .fec_enable(fec_enable));
  xrp_assertions xrp_assertions_i (.clk_sys(clk_sys), .rst_n(rst_n),
    .address(xrp_avmm_if_i.address), .read(xrp_avmm_if_i.read), .write(xrp_avmm_if_i.write),
    .writedata(xrp_avmm_if_i.writedata), .readdata(xrp_avmm_if_i.readdata),
    .waitrequest(xrp_avmm_if_i.waitrequest));

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] d,
    input logic [7:0] m);
    return (old & ~m) | (d & m);
  endfunction : merge

  task automatic chk_cmd(input logic wr, input logic [18:0] ad, input logic [7:0] d,
    input logic [7:0] m, input logic step, input logic [7:0] dl, input logic uns,
    input logic exp_err);
    int n;
    logic [7:0] old, expv;
    logic mapped;
    mapped = ad[18:11] == 8'h00;
    old = mapped ? ref_mem[ad[10:0]] : xrp_pkg::DATA_ZERO;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 50)
    begin
      @(negedge clk_sys);
      n++;
    end
    cmd_write = wr;
    cmd_addr = ad;
    cmd_wdata = d;
    cmd_mask = m;
    cmd_rate_step = step;
    cmd_rate_delta = dl;
    cmd_unsupported = uns;
    cmd_valid = 1'b1;
    @(negedge clk_sys);
    cmd_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 50)
    begin
      @(negedge clk_sys);
      n++;
    end
    `CHK(rsp_valid, 1'b1)
    `CHK(rsp_error, exp_err)
    if (exp_err)
      return;
    if (wr)
    begin
      `CHK(rsp_data, merge(old, d, m))
      if (mapped && !(ad[7:0] == xrp_pkg::MODE_OFS && !pma_direct[ad[10:8]]))
        ref_mem[ad[10:0]] = merge(old, d, m);
    end
    else
      `CHK(rsp_data, old)
    for (int c = 0; c < 8; c++)
      expv[c] = ref_mem[c * 256 + 128][0];
    `CHK(pam4_mode, expv)
    `CHK(fec_enable, 1'b0)
  endtask : chk_cmd

  task automatic close_out();
    $display("checks=%0d mismatches=%0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : close_out

  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  initial
  begin
    #200000;
    n_mismatch++;
    close_out();
  end

  // ****************************************************************
  // scenarios
  // ****************************************************************
  initial
  begin
    n_mismatch = 0;
    check_count = 0;
    seed = 32'h450C1BD3;
    {cmd_valid, cmd_write, cmd_rate_step, cmd_unsupported, pam4_hi_active} = 5'h00;
    {cmd_addr, cmd_wdata, cmd_mask, cmd_rate_delta} = '0;
    pma_direct = 8'hFF;
    for (int i = 0; i < 2048; i++)
      ref_mem[i] = 8'h00;
    rst_n = 1'b0;
    repeat (10) @(negedge clk_sys);
    `CHK(xrp_avmm_if_i.waitrequest, 1'b1)
    `CHK(xrp_avmm_if_i.readdata, xrp_pkg::DATA_ZERO)
    `CHK({pam4_mode, fec_enable, cmd_ready}, 10'h001)
    rst_n = 1'b1;
    // every channel on the shared port: mode byte, bridge byte, read back
    for (int c = 0; c < 8; c++)
    begin
      pma_direct = 8'hFF;
      chk_cmd(1'b1, {8'h00, 3'(c), xrp_pkg::MODE_OFS}, 8'h01, 8'h01,
        1'b0, 8'h00, 1'b0, 1'b0);
      chk_cmd(1'b1, {8'h00, 3'(c), 8'hFF}, 8'hA5, 8'hFF, 1'b0, 8'h00, 1'b0, 1'b0);
      chk_cmd(1'b0, {8'h00, 3'(c), 8'hFF}, 8'h00, 8'h00, 1'b0, 8'h00, 1'b0, 1'b0);
      pma_direct = 8'h00;
      chk_cmd(1'b1, {8'h00, 3'(c), xrp_pkg::MODE_OFS}, 8'h00, 8'h01,
        1'b0, 8'h00, 1'b0, 1'b0);
    end
    for (int i = 0; i < 80; i++)
    begin
      seed = xs(seed);
      pma_direct = seed[7:0];
      a = {(seed[10:8] == 3'h0) ? 8'h5A : 8'h00, seed[13:11],
        seed[14] ? xrp_pkg::MODE_OFS : seed[22:15]};
      seed = xs(seed);
      wd = seed[7:0];
      mk = seed[15:8];
      chk_cmd(seed[16], a, wd, mk, 1'b0, 8'h00, 1'b0, 1'b0);
      chk_cmd(1'b0, a, 8'h00, 8'h00, 1'b0, 8'h00, 1'b0, 1'b0);
    end
    // refused requests and rate stepping
    chk_cmd(1'b1, 19'h00010, 8'h3C, 8'hFF, 1'b0, 8'h00, 1'b1, 1'b1);
    chk_cmd(1'b0, 19'h00010, 8'h00, 8'h00, 1'b0, 8'h00, 1'b1, 1'b1);
    pam4_hi_active = 1'b1;
    chk_cmd(1'b1, 19'h00020, 8'h11, 8'hFF, 1'b1, 8'h15, 1'b0, 1'b1);
    chk_cmd(1'b1, 19'h00020, 8'h22, 8'hFF, 1'b1, 8'h14, 1'b0, 1'b0);
    chk_cmd(1'b1, 19'h00020, 8'h33, 8'hFF, 1'b1, 8'h05, 1'b0, 1'b1);
    repeat (HOLD + 4) @(negedge clk_sys);
    chk_cmd(1'b1, 19'h00020, 8'h44, 8'hFF, 1'b1, 8'h05, 1'b0, 1'b0);
    pam4_hi_active = 1'b0;
    repeat (HOLD + 4) @(negedge clk_sys);
    chk_cmd(1'b1, 19'h00020, 8'h55, 8'hF0, 1'b1, 8'h28, 1'b0, 1'b0);
    chk_cmd(1'b0, 19'h00020, 8'h00, 8'h00, 1'b0, 8'h00, 1'b0, 1'b0);
    close_out();
  end
endmodule : tb
